// ===== testbench.sv
// self-checking bench of the usb fifo slave host port
`timescale 1ns/10ps
module testbench;
    import ufsp_pkg::*;
    localparam int D = 16;
    logic core_clk, rst_b, cs_b, rd, wr, oe, pk, wk, int_b, ready;
    logic doe, fa, fb, fc, hs, lp;
    logic [2:0] sel;
    logic [15:0] din, dout, push_data, w;
    logic [3:0] push, push_rdy, pop, pop_vld, commit;
    logic [63:0] pop_data;
    logic [15:0] mdl[4][$];
    int failures = 0, samples_checked = 0, seed = 30, n, i, k, m;
    ufsp_host_port #(.DEPTH(D)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .host_chip_select_b(cs_b), .fifo_select(sel),
        .slave_read_strobe(rd), .slave_write_strobe(wr),
        .slave_output_enable(oe), .packet_commit_b(pk),
        .wake_request_in(wk), .fifo_data_in(din), .fifo_data_out(dout),
        .fifo_data_oe(doe), .int_b(int_b), .ready(ready), .flag_a(fa),
        .flag_b(fb), .flag_c(fc), .usb_push(push),
        .usb_push_data(push_data), .usb_push_ready(push_rdy),
        .usb_pop(pop), .usb_pop_valid(pop_vld), .usb_pop_data(pop_data),
        .usb_commit(commit), .usb_high_speed(hs), .low_power(lp));
    ufsp_host_model i_host (.core_clk(core_clk), .ready(ready),
        .host_chip_select_b(cs_b), .fifo_select(sel),
        .slave_read_strobe(rd), .slave_write_strobe(wr),
        .slave_output_enable(oe), .packet_commit_b(pk),
        .wake_request_in(wk), .fifo_data_in(din));
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic finish_test();
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic expire(input int left);
        if (left <= 0)
        begin
            failures++;
            $display("[ERR] %0t wait ran out", $time);
            finish_test();
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(negedge core_clk);
    endtask
    task automatic read_status(input int bit_no);
        i_host.pins(1'b0, SEL_CMD, 1'b1, 1'b1, 1'b0);
        tick(2);
        check(dout[bit_no], 1'b1);
        i_host.pulse();
        tick(3);
        check(int_b, 1'b1);
    endtask
    // write a register, then measure the busy window
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] v);
        i_host.reg_write(a, v);
        for (n = 6; ready !== 1'b0 && n > 0; n--)
            tick(1);
        expire(n);
        for (m = 0; ready === 1'b0 && m < 9; m++)
            tick(1);
        check(m[15:0], 16'(READY_BUSY_CYC));
    endtask
    task automatic drain(input int f);
        while (mdl[f].size() > 0)
        begin
            tick(1);
            check(pop_vld[f], 1'b1);
            check(pop_data[16*f +: 16], mdl[f].pop_front());
            @(posedge core_clk);
            pop <= 4'h1 << f;
            @(posedge core_clk);
            pop <= 4'h0;
        end
        tick(3);
        check(pop_vld[f], 1'b0);
        check(fc, 1'b1);
    endtask
    initial
    begin
        rst_b = 1'b0;
        {push, pop, push_data} = 24'h0;
        tick(20);
        check(fa, 1'b0);
        check(fb, 1'b0);
        check(fc, 1'b1);
        check(int_b, 1'b1);
        check(hs, 1'b1);
        check(lp, 1'b0);
        check(doe, 1'b0);
        check(push_rdy, 4'hf);
        @(posedge core_clk);
        rst_b <= 1'b1;
        i_host.cmd({2'h3, REG_INT_EN});
        for (n = 20; int_b !== 1'b0 && n > 0; n--)
            tick(1);
        expire(n);
        read_status(INT_RDDATA);
        check(dout, {8'h00, INT_EN_RST});
        for (k = 0; k < 2; k++)
        begin
            reg_wr(REG_SPEED, k[7:0]);
            check(hs, k[0]);
        end
        i_host.reg_write(REG_POWER, 8'h01);
        tick(3);
        check(lp, 1'b1);
        check(ready, 1'b0);
        i_host.pins(1'b1, 3'h0, 1'b0, 1'b1, 1'b1);
        i_host.pins(1'b1, 3'h0, 1'b0, 1'b1, 1'b0);
        tick(3);
        check(lp, 1'b0);
        check(int_b, 1'b0);
        read_status(INT_WAKE);
        reg_wr(REG_PF_THRESH, 8'h04);
        for (i = 0; i < 4; i++)
        begin
            m = (i == 1) ? D + 2 : 3;
            for (k = 0; k < m; k++)
            begin
                w = $random(seed);
                i_host.put(i[2:0], w, 1'b1);
                if (mdl[i].size() < D)
                    mdl[i].push_back(w);
            end
            i_host.put(i[2:0], 16'h0, 1'b0);
            tick(3);
            check(fa, mdl[i].size() >= (8'h04 << PF_SHIFT));
            check(fb, mdl[i].size() == D);
            check(fc, 1'b0);
            check(push_rdy[i], mdl[i].size() < D);
            drain(i);
        end
        for (k = 0; k < 3; k++)
        begin
            w = $random(seed);
            @(posedge core_clk);
            push <= 4'h8;
            push_data <= w;
            mdl[3].push_back(w);
        end
        @(posedge core_clk);
        push <= 4'h0;
        i_host.pins(1'b0, 3'h3, 1'b1, 1'b1, 1'b0);
        tick(2);
        while (mdl[3].size() > 0)
        begin
            check(doe, 1'b1);
            check(dout, mdl[3].pop_front());
            i_host.pulse();
            tick(3);
        end
        i_host.pins(1'b0, 3'h3, 1'b0, 1'b1, 1'b0);
        tick(1);
        check(doe, 1'b0);
        check(pop_vld[3], 1'b0);
        for (i = 0; i < 4; i++)
        begin
            i_host.pins(1'b0, i[2:0], 1'b0, 1'b0, 1'b0);
            i_host.pins(1'b0, i[2:0], 1'b0, 1'b1, 1'b0);
            for (n = 4; commit === 4'h0 && n > 0; n--)
                tick(1);
            expire(n);
            check(commit, 4'h1 << i);
            tick(1);
            check(commit, 4'h0);
        end
        check(i_host.errs, 0);
        finish_test();
    end
endmodule

// ===== ufsp_ep_fifo.sv
// one endpoint fifo: flip-flop storage, pointers, level and flags
`timescale 1ns/10ps
module ufsp_ep_fifo
#(
    parameter int DATA_W = 16,
    parameter int DEPTH = 512
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [$clog2(DEPTH):0] thresh,
    output logic [DATA_W-1:0] head,
    output logic [$clog2(DEPTH):0] level,
    output logic full,
    output logic empty,
    output logic prog_flag
);
    localparam int AW = $clog2(DEPTH);
    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;

    // storage carries no reset, it is never read while empty
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            mem[wp] <= wr_data;
    end

    // depth must be a power of two so the pointers wrap by themselves
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp <= '0;
            rp <= '0;
        end
        else
        begin
            if (wr_en)
                wp <= wp + AW'(1);
            if (rd_en)
                rp <= rp + AW'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            level <= '0;
        else if (wr_en && !rd_en)
            level <= level + (AW+1)'(1);
        else if (rd_en && !wr_en)
            level <= level - (AW+1)'(1);
    end

    assign head = mem[rp];
    assign full = level == (AW+1)'(DEPTH);
    assign empty = level == '0;
    assign prog_flag = level >= thresh;
endmodule

// ===== ufsp_host_model.sv
// host-side model: strobed master on the slave port, driving its pins on core_clk rising edges
`timescale 1ns/10ps
module ufsp_host_model
(
    input wire logic core_clk,
    input wire logic ready,
    output logic host_chip_select_b,
    output logic [ufsp_pkg::SEL_W-1:0] fifo_select,
    output logic slave_read_strobe,
    output logic slave_write_strobe,
    output logic slave_output_enable,
    output logic packet_commit_b,
    output logic wake_request_in,
    output logic [ufsp_pkg::DATA_W-1:0] fifo_data_in
);
    import ufsp_pkg::*;
    int errs = 0;
    initial
    begin
        {host_chip_select_b, slave_output_enable} = 2'h2;
        {slave_read_strobe, slave_write_strobe, wake_request_in} = 3'h0;
        packet_commit_b = 1'b1;
        fifo_select = 3'h0;
        fifo_data_in = 16'h0;
    end
    // windows sit every 2 KB; select pins carry byte address bits 13..11
    function automatic logic [2:0] win(input logic [2:0] sel);
        logic [20:0] addr;
        addr = {7'h00, sel, 11'h000};
        return addr[13:11];
    endfunction
    task automatic pins(input logic cs_b, input logic [2:0] sel,
        input logic oe, input logic pk, input logic wk);
        @(posedge core_clk);
        host_chip_select_b <= cs_b;
        fifo_select <= win(sel);
        slave_output_enable <= oe;
        packet_commit_b <= pk;
        wake_request_in <= wk;
    endtask
    // one word per edge while the strobe is held
    task automatic put(input logic [2:0] sel, input logic [15:0] w,
        input logic wr);
        @(posedge core_clk);
        host_chip_select_b <= 1'b0;
        fifo_select <= win(sel);
        slave_output_enable <= 1'b0;
        slave_write_strobe <= wr;
        // a released bus must not keep showing the last word
        fifo_data_in <= wr ? w : ~fifo_data_in;
    endtask
    task automatic pulse();
        @(posedge core_clk);
        slave_read_strobe <= 1'b1;
        @(posedge core_clk);
        slave_read_strobe <= 1'b0;
    endtask
    // the strobe drops between bytes so each byte is a fresh rise
    task automatic cmd(input logic [7:0] b);
        int n;
        n = 40;
        do
        begin
            @(posedge core_clk);
            n--;
        end
        while (ready !== 1'b1 && n > 0);
        if (n == 0)
            errs++;
        put(SEL_CMD, {8'h00, b}, 1'b1);
        put(SEL_CMD, 16'h0, 1'b0);
    endtask
    task automatic reg_write(input logic [5:0] a, input logic [7:0] v);
        cmd({2'h2, a});
        cmd({4'h0, v[7:4]});
        cmd({4'h0, v[3:0]});
    endtask
endmodule

// ===== ufsp_host_port.sv
// usb fifo slave host port: endpoint fifos, flags and command interface
`timescale 1ns/10ps
// Overview of operation
// - interrupt output low while an enabled event, read data included, waits
// - ready gates command accesses; host commands only while ready high
// - first flag follows selected fifo, programmable flag after reset
// - second flag follows selected fifo, full flag after reset
// - third flag follows selected fifo, empty flag after reset
// - wake input brings the device out of low-power mode
// - data bus driven only while slave output enable asserted
// - read strobe advances selected fifo read pointer each clock
// - write strobe stores bus word and advances write pointer each clock
// - packet commit input hands current buffer to usb; idles high
// - eight 512-byte blocks, 4K bytes, form the fifo storage
// - four endpoint fifos two, four, six, eight share the buffer
// - separate command interface for setup and status
// - three select pins pick a fifo or the command interface
// - bidirectional data bus carries commands and fifo data
// - usb side programmable to high or full speed
// - host chip select drives the device select pin
// - with interrupt asserted, status byte sits on low data bits
module ufsp_host_port
#(
    parameter int DEPTH = ufsp_pkg::EP_DEPTH
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic host_chip_select_b,
    input wire logic [ufsp_pkg::SEL_W-1:0] fifo_select,
    input wire logic slave_read_strobe,
    input wire logic slave_write_strobe,
    input wire logic slave_output_enable,
    input wire logic packet_commit_b,
    input wire logic wake_request_in,
    input wire logic [ufsp_pkg::DATA_W-1:0] fifo_data_in,
    output logic [ufsp_pkg::DATA_W-1:0] fifo_data_out,
    output logic fifo_data_oe,
    output logic int_b,
    output logic ready,
    output logic flag_a,
    output logic flag_b,
    output logic flag_c,
    input wire logic [ufsp_pkg::NUM_EP-1:0] usb_push,
    input wire logic [ufsp_pkg::DATA_W-1:0] usb_push_data,
    output logic [ufsp_pkg::NUM_EP-1:0] usb_push_ready,
    input wire logic [ufsp_pkg::NUM_EP-1:0] usb_pop,
    output logic [ufsp_pkg::NUM_EP-1:0] usb_pop_valid,
    output logic [ufsp_pkg::NUM_EP*ufsp_pkg::DATA_W-1:0] usb_pop_data,
    output logic [ufsp_pkg::NUM_EP-1:0] usb_commit,
    output logic usb_high_speed,
    output logic low_power
);
    import ufsp_pkg::*;

    localparam int LW = $clog2(DEPTH) + 1;
    localparam int TW = REG_W + PF_SHIFT;
    logic [TW-1:0] thresh_raw;
    logic sel_fifo;
    logic sel_cmd;
    logic [EP_IDX_W-1:0] ep_idx;
    logic [NUM_EP-1:0] host_wr;
    logic [NUM_EP-1:0] host_rd;
    logic [NUM_EP-1:0] fifo_wr;
    logic [NUM_EP-1:0] fifo_rd;
    logic [NUM_EP-1:0] full;
    logic [NUM_EP-1:0] empty;
    logic [NUM_EP-1:0] pf;
    logic [NUM_EP-1:0] pf_q;
    logic [DATA_W-1:0] head [NUM_EP];
    logic [LW-1:0] level [NUM_EP];
    logic [LW-1:0] thresh;
    logic commit_q;
    logic wr_q;
    logic rd_q;
    logic cmd_wr;
    logic cmd_rd_done;
    logic reg_wr;
    logic rd_req;
    logic [REG_W-1:0] reg_wdata;
    logic [REG_ADDR_W-1:0] req_addr;
    ufsp_cmd_state_t cmd_state;
    logic [REG_ADDR_W-1:0] cmd_addr;
    logic [NIB_W-1:0] nib_hi;
    logic [REG_W-1:0] int_en;
    logic [REG_W-1:0] flag_cfg;
    logic [REG_W-1:0] pf_thresh;
    logic [REG_W-1:0] rd_data;
    logic [REG_W-1:0] int_stat;
    logic [REG_W-1:0] shown_stat;
    logic [REG_W-1:0] ev;
    logic [3:0] busy;

    // chip select qualifies every host access
    assign sel_fifo = !host_chip_select_b && (fifo_select < SEL_CMD);
    assign sel_cmd = !host_chip_select_b && (fifo_select == SEL_CMD);
    assign ep_idx = fifo_select[EP_IDX_W-1:0];
    assign fifo_data_oe = slave_output_enable && !host_chip_select_b;
    // a threshold past the fifo depth can never be met, so saturate it
    // instead of letting the upper bits wrap it down to a tiny value
    assign thresh_raw = TW'(pf_thresh) << PF_SHIFT;
    assign thresh = (int'(thresh_raw) > DEPTH) ? '1 : LW'(thresh_raw);

    // four fifos carve the shared buffer; host side has priority over usb
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++)
        begin : gen_ep
            assign host_wr[g] = sel_fifo && slave_write_strobe
                && ep_idx == EP_IDX_W'(g) && !full[g];
            assign host_rd[g] = sel_fifo && slave_read_strobe
                && ep_idx == EP_IDX_W'(g) && !empty[g];
            assign usb_push_ready[g] = !full[g] && !host_wr[g];
            assign usb_pop_valid[g] = !empty[g] && !host_rd[g];
            assign fifo_wr[g] = host_wr[g]
                || (usb_push[g] && usb_push_ready[g]);
            assign fifo_rd[g] = host_rd[g] || (usb_pop[g] && usb_pop_valid[g]);
            assign usb_pop_data[g*DATA_W +: DATA_W] = head[g];
            ufsp_ep_fifo #(
                .DATA_W(DATA_W),
                .DEPTH(DEPTH)
            ) u_fifo (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .wr_en(fifo_wr[g]),
                .wr_data(host_wr[g] ? fifo_data_in : usb_push_data),
                .rd_en(fifo_rd[g]),
                .thresh(thresh),
                .head(head[g]),
                .level(level[g]),
                .full(full[g]),
                .empty(empty[g]),
                .prog_flag(pf[g])
            );
        end
    endgenerate

    // packet commit idles high; a falling edge hands the buffer to usb
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            commit_q <= 1'h1;
            usb_commit <= '0;
        end
        else
        begin
            commit_q <= packet_commit_b;
            usb_commit <= '0;
            if (commit_q && !packet_commit_b && sel_fifo)
                usb_commit[ep_idx] <= 1'h1;
        end
    end

    function automatic logic pick(input logic [1:0] src, input logic p,
                                  input logic f, input logic e);
        logic r;
        r = p;
        if (src == FLAG_SRC_FULL)
            r = f;
        else if (src == FLAG_SRC_EMPTY)
            r = e;
        return r;
    endfunction

    // flags hold their last value while the command code is selected
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flag_a <= 1'h0;
            flag_b <= 1'h0;
            flag_c <= 1'h1;
        end
        else if (fifo_select < SEL_CMD)
        begin
            flag_a <= pick(flag_cfg[FLAG_A_LSB +: FLAG_SRC_W], pf[ep_idx],
                full[ep_idx], empty[ep_idx]);
            flag_b <= pick(flag_cfg[FLAG_B_LSB +: FLAG_SRC_W], pf[ep_idx],
                full[ep_idx], empty[ep_idx]);
            flag_c <= pick(flag_cfg[FLAG_C_LSB +: FLAG_SRC_W], pf[ep_idx],
                full[ep_idx], empty[ep_idx]);
        end
    end

    // command bytes are taken once per strobe, on its rising edge
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_q <= 1'h0;
            rd_q <= 1'h0;
        end
        else
        begin
            wr_q <= slave_write_strobe;
            rd_q <= slave_read_strobe;
        end
    end

    assign cmd_wr = sel_cmd && slave_write_strobe && !wr_q && ready;
    assign cmd_rd_done = sel_cmd && rd_q && !slave_read_strobe;
    assign req_addr = fifo_data_in[REG_ADDR_W-1:0];
    assign rd_req = cmd_wr && cmd_state == CMD_IDLE
        && fifo_data_in[CMD_ADDR_BIT] && fifo_data_in[CMD_READ_BIT];
    assign reg_wr = cmd_wr && cmd_state == CMD_DATA2;
    assign reg_wdata = {nib_hi, fifo_data_in[NIB_W-1:0]};

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmd_state <= CMD_IDLE;
            cmd_addr <= '0;
            nib_hi <= '0;
        end
        else if (cmd_wr)
        begin
            case (cmd_state)
                CMD_IDLE:
                begin
                    cmd_addr <= req_addr;
                    if (fifo_data_in[CMD_ADDR_BIT]
                        && !fifo_data_in[CMD_READ_BIT])
                        cmd_state <= CMD_DATA1;
                end
                CMD_DATA1:
                begin
                    nib_hi <= fifo_data_in[NIB_W-1:0];
                    cmd_state <= CMD_DATA2;
                end
                default:
                    cmd_state <= CMD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            int_en <= INT_EN_RST;
            flag_cfg <= FLAG_CFG_RST;
            pf_thresh <= PF_THRESH_RST;
            usb_high_speed <= SPEED_RST;
        end
        else if (reg_wr)
        begin
            if (cmd_addr == REG_INT_EN)
                int_en <= reg_wdata;
            else if (cmd_addr == REG_FLAG_CFG)
                flag_cfg <= reg_wdata;
            else if (cmd_addr == REG_PF_THRESH)
                pf_thresh <= reg_wdata;
            else if (cmd_addr == REG_SPEED)
                usb_high_speed <= reg_wdata[SPEED_BIT];
        end
    end

    // a wake request beats a same-cycle write that asks for low power
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            low_power <= 1'h0;
        else if (wake_request_in)
            low_power <= 1'h0;
        else if (reg_wr && cmd_addr == REG_POWER)
            low_power <= reg_wdata[POWER_BIT];
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data <= '0;
        else if (rd_req)
        begin
            if (req_addr == REG_INT_EN)
                rd_data <= int_en;
            else if (req_addr == REG_FLAG_CFG)
                rd_data <= flag_cfg;
            else if (req_addr == REG_PF_THRESH)
                rd_data <= pf_thresh;
            else if (req_addr == REG_SPEED)
                rd_data <= REG_W'(usb_high_speed);
            else if (req_addr == REG_POWER)
                rd_data <= REG_W'(low_power);
            else
                rd_data <= '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            busy <= '0;
        else if (reg_wr || rd_req)
            busy <= READY_BUSY_CYC;
        else if (busy != '0)
            busy <= busy - 4'h1;
    end

    assign ready = busy == '0 && !low_power;

    always_comb
    begin
        ev = '0;
        ev[INT_RDDATA] = rd_req;
        ev[INT_PF] = |(pf & ~pf_q);
        ev[INT_WAKE] = wake_request_in && low_power;
    end

    // only the bits the host actually saw are cleared; new events win
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pf_q <= '0;
            shown_stat <= '0;
            int_stat <= '0;
        end
        else
        begin
            pf_q <= pf;
            // a read with no interrupt showing must clear nothing later
            if (sel_cmd && slave_read_strobe && !rd_q)
                shown_stat <= int_b ? '0 : int_stat;
            if (cmd_rd_done)
                int_stat <= (int_stat & ~shown_stat) | ev;
            else
                int_stat <= int_stat | ev;
        end
    end

    assign int_b = !(|(int_stat & int_en));

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            fifo_data_out <= '0;
        else if (fifo_select == SEL_CMD)
            fifo_data_out <= DATA_W'(int_b ? rd_data : int_stat);
        else
            fifo_data_out <= head[ep_idx];
    end

    property p_int_event;
        @(posedge core_clk) disable iff (!rst_b)
        |(ev & int_en) |=> !int_b;
    endproperty
    a_int_event: assert property (p_int_event)
        else $error("enabled event did not assert interrupt");

    property p_ready_busy;
        @(posedge core_clk) disable iff (!rst_b)
        reg_wr |=> !ready [*3];
    endproperty
    a_ready_busy: assert property (p_ready_busy)
        else $error("ready rose too early after a command");

    property p_flag_a;
        @(posedge core_clk) disable iff (!rst_b)
        fifo_select < SEL_CMD
        && flag_cfg[FLAG_A_LSB +: FLAG_SRC_W] == FLAG_SRC_PF
        |=> flag_a == $past(pf[ep_idx]);
    endproperty
    a_flag_a: assert property (p_flag_a)
        else $error("first flag does not follow threshold flag");

    property p_flag_c;
        @(posedge core_clk) disable iff (!rst_b)
        fifo_select < SEL_CMD
        && flag_cfg[FLAG_C_LSB +: FLAG_SRC_W] == FLAG_SRC_EMPTY
        |=> flag_c == $past(empty[ep_idx]);
    endproperty
    a_flag_c: assert property (p_flag_c)
        else $error("third flag does not follow empty");

    property p_wake;
        @(posedge core_clk) disable iff (!rst_b)
        wake_request_in |=> !low_power;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake request did not leave low power");

    property p_bus_release;
        @(posedge core_clk) disable iff (!rst_b)
        fifo_data_oe |-> slave_output_enable && !host_chip_select_b;
    endproperty
    a_bus_release: assert property (p_bus_release)
        else $error("data bus driven without output enable");

    property p_read_adv;
        @(posedge core_clk) disable iff (!rst_b)
        host_rd[NUM_EP-1] && !fifo_wr[NUM_EP-1]
        |=> level[NUM_EP-1] == $past(level[NUM_EP-1]) - 1'b1;
    endproperty
    a_read_adv: assert property (p_read_adv)
        else $error("read strobe did not advance fifo");

    property p_write_store;
        @(posedge core_clk) disable iff (!rst_b)
        host_wr[0] && !fifo_rd[0] |=> level[0] == $past(level[0]) + 1'b1;
    endproperty
    a_write_store: assert property (p_write_store)
        else $error("write strobe did not fill fifo");

    property p_commit;
        @(posedge core_clk) disable iff (!rst_b)
        commit_q && !packet_commit_b && sel_fifo |=> usb_commit != '0 ##1
        usb_commit == '0;
    endproperty
    a_commit: assert property (p_commit)
        else $error("packet commit pulse missing");

    property p_status_bus;
        @(posedge core_clk) disable iff (!rst_b)
        fifo_select == SEL_CMD && !int_b
        |=> fifo_data_out[REG_W-1:0] == $past(int_stat);
    endproperty
    a_status_bus: assert property (p_status_bus)
        else $error("status byte not on data bus");
endmodule

// ===== ufsp_pkg.sv
// shared constants and types of the usb fifo slave host port
package ufsp_pkg;
    localparam int DATA_W = 16;
    localparam int SEL_W = 3;
    localparam int NUM_EP = 4;
    localparam int EP_IDX_W = 2;
    localparam int BLOCK_BYTES = 512;
    localparam int NUM_BLOCKS = 8;
    localparam int WORD_BYTES = 2;
    localparam int BUF_BYTES = NUM_BLOCKS * BLOCK_BYTES;
    localparam int EP_DEPTH = BUF_BYTES / (NUM_EP * WORD_BYTES);
    localparam logic [2:0] SEL_CMD = 3'h4;
    localparam int CMD_ADDR_BIT = 7;
    localparam int CMD_READ_BIT = 6;
    localparam int REG_ADDR_W = 6;
    localparam int NIB_W = 4;
    localparam int REG_W = 8;
    localparam logic [5:0] REG_SPEED = 6'h00;
    localparam logic [5:0] REG_INT_EN = 6'h01;
    localparam logic [5:0] REG_FLAG_CFG = 6'h02;
    localparam logic [5:0] REG_PF_THRESH = 6'h03;
    localparam logic [5:0] REG_POWER = 6'h04;
    localparam int SPEED_BIT = 0;
    localparam int POWER_BIT = 0;
    localparam logic SPEED_RST = 1'h1;
    localparam logic [7:0] INT_EN_RST = 8'h07;
    localparam logic [7:0] FLAG_CFG_RST = 8'h24;
    localparam logic [7:0] PF_THRESH_RST = 8'h80;
    localparam int PF_SHIFT = 1;
    localparam int FLAG_SRC_W = 2;
    localparam int FLAG_A_LSB = 0;
    localparam int FLAG_B_LSB = 2;
    localparam int FLAG_C_LSB = 4;
    localparam logic [1:0] FLAG_SRC_PF = 2'h0;
    localparam logic [1:0] FLAG_SRC_FULL = 2'h1;
    localparam logic [1:0] FLAG_SRC_EMPTY = 2'h2;
    localparam int INT_RDDATA = 0;
    localparam int INT_PF = 1;
    localparam int INT_WAKE = 2;
    localparam logic [3:0] READY_BUSY_CYC = 4'h3;
    typedef enum logic [1:0] {CMD_IDLE, CMD_DATA1, CMD_DATA2} ufsp_cmd_state_t;
endpackage
